/* include/sensor_diag_regs.vh */
/*
 * Constants of the safety sensor diagnostic status block: bit positions of the
 * serial status bytes, flash timing and the delayed shutdown time.
 * Assumes a single 10 MHz clock and sensing inputs already synchronous to it.
 */
// Operation
// RULE1: Active fault forces diagnostic output low.
// RULE2: Uncleared fault shuts outputs within 30 minutes.
// RULE3: Idle: green only, all outputs low.
// RULE4: Released actuation: yellow on, outputs high.
// RULE5: Limit area: yellow 1 Hz, diagnostic pulsed.
// RULE6: Feedback open: yellow 5 Hz, outputs off.
// RULE7: Limit and feedback open: alternating flash.
// RULE8: Warning: red flash, outputs on until expiry.
// RULE9: Error: red code, yellow on, outputs low.
// RULE10: Chain of 30 plus one, relayed.
// RULE11: Response byte bit meanings as listed.
// RULE12: Communication loss freezes safety outputs.
// RULE13: Fault clears: cause gone, reset or guard.
// RULE14: Output faults clear only at release.
// RULE15: Warning clears itself when cause gone.
// RULE16: Controller sends request byte, resets bits.
// RULE17: Warning byte bit meanings as listed.
// RULE18: Error byte bit meanings as listed.
// RULE19: Bit one means condition present.
// RULE20: Red pulse count encodes fault cause.
// RULE21: Unassigned diagnostic bits read zero.
`ifndef SENSOR_DIAG_REGS_VH
`define SENSOR_DIAG_REGS_VH

`define CLOCK_HZ            10000000
`define FAST_FLASH_HZ       5
`define SLOW_FLASH_HZ       1
`define SHUTDOWN_MINUTES    30
`define SHUTDOWN_SECONDS    (`SHUTDOWN_MINUTES * 60)
`define HALF_FAST_CYCLES    (`CLOCK_HZ / (2 * `FAST_FLASH_HZ))
`define HALF_SLOW_CYCLES    (`CLOCK_HZ / (2 * `SLOW_FLASH_HZ))
`define CHAIN_MAX_PLAIN     30

`define REQ_RESET_LOW       0
`define REQ_RESET_HIGH      7

`define RSP_OUT_ON          0
`define RSP_ACTUATOR        1
`define RSP_START_MISSING   3
`define RSP_INPUTS_LIVE     4
`define RSP_LIMIT           5
`define RSP_WARNING         6
`define RSP_ERROR           7

`define DIAG_OUT_A          0
`define DIAG_OUT_B          1
`define DIAG_CROSS          2
`define DIAG_TEMP           3
`define DIAG_ACTUATOR       4
`define DIAG_INTERNAL       5
`define DIAG_COMM           6
`define DIAG_LOW_SUPPLY     7

`define FLASH_STEPS         16
`define STEP_BITS           4
`define CODE_CONTINUOUS     3'h7
`define CODE_NONE           3'h0

`endif

/* logic/flash_timebase.v */
/*
 * Time base for the indicators: one-cycle enables at each half period of the
 * fast and slow flash rates and the matching square waves.
 * Assumes one clock; the half-period counts arrive as parameters.
 */
`include "sensor_diag_regs.vh"

module flash_timebase #(
    parameter HALF_FAST = `HALF_FAST_CYCLES,  // Cycles per half period, fast flash.
    parameter HALF_SLOW = `HALF_SLOW_CYCLES   // Cycles per half period, slow flash.
) (
    input  wire mclk,       // System clock.
    input  wire reset,      // Synchronous reset, active high.
    output reg  fast_tick,  // Pulse at each fast half period.
    output reg  slow_tick,  // Pulse at each slow half period.
    output reg  fast_wave,  // Fast square wave.
    output reg  slow_wave   // Slow square wave.
);
    reg [23:0] fast_count;
    reg [23:0] slow_count;

    always @(posedge mclk) begin
        if (reset) begin
            fast_count <= 24'h000000;
            slow_count <= 24'h000000;
            fast_tick  <= 1'b0;
            slow_tick  <= 1'b0;
            fast_wave  <= 1'b0;
            slow_wave  <= 1'b0;
        end else begin
            fast_tick <= 1'b0;
            slow_tick <= 1'b0;
            if (fast_count == HALF_FAST[23:0] - 24'h000001) begin
                fast_count <= 24'h000000;
                fast_tick  <= 1'b1;
                fast_wave  <= ~fast_wave;
            end else begin
                fast_count <= fast_count + 24'h000001;
            end
            if (slow_count == HALF_SLOW[23:0] - 24'h000001) begin
                slow_count <= 24'h000000;
                slow_tick  <= 1'b1;
                slow_wave  <= ~slow_wave;
            end else begin
                slow_count <= slow_count + 24'h000001;
            end
        end
    end
endmodule

/* logic/safety_sensor_diagnostic_status.v */
/*
 * Diagnostic status logic of a non-contact safety sensor: indicator LEDs,
 * diagnostic output, both safety outputs, fault latching, unlatched warning flags, the
 * delayed shutdown after a warning and the status bytes for the controller.
 * Assumes all sensing inputs are synchronous to mclk and already debounced.
 */
`include "sensor_diag_regs.vh"

module safety_sensor_diagnostic_status #(
    parameter HALF_FAST        = `HALF_FAST_CYCLES, // Fast flash half period in cycles.
    parameter HALF_SLOW        = `HALF_SLOW_CYCLES, // Slow flash half period in cycles.
    parameter SHUTDOWN_SECONDS = `SHUTDOWN_SECONDS  // Warning to shutdown, slow periods.
) (
    input  wire       mclk,                  // System clock, 10 MHz.
    input  wire       reset,                 // Synchronous reset, active high.
    input  wire       variant_edge_feedback, // 1: release on trailing edge, 0: on level.
    input  wire       actuator_present,      // Actuator within range.
    input  wire       limit_area,            // Actuator in hysteresis area.
    input  wire       feedback_closed,       // Feedback circuit closed.
    input  wire       safety_input_a,        // Safety input A live.
    input  wire       safety_input_b,        // Safety input B live.
    input  wire [5:0] fault_cause,           // Fault causes, error byte order.
    input  wire [7:0] warning_cause,         // Warning causes, warning byte order.
    input  wire       comm_error,            // Link to gateway lost.
    input  wire [7:0] host_request_byte,     // Request byte from controller.
    input  wire       request_valid,         // Request byte is current.
    input  wire       serial_diag_in,        // Serial diagnostic line from upstream.
    output reg        serial_diag_out,       // Serial diagnostic line to downstream.
    output reg        led_green,             // Green indicator.
    output reg        led_red,               // Red indicator.
    output reg        led_yellow,            // Yellow indicator.
    output reg        diag_output,           // Diagnostic output, 1 = 24 V.
    output reg        safety_output_a,       // Safety output A, 1 = 24 V.
    output reg        safety_output_b,       // Safety output B, 1 = 24 V.
    output reg  [7:0] sensor_response_byte,  // Status for the controller.
    output reg  [7:0] warning_diag_byte,     // Warning flags.
    output reg  [7:0] error_diag_byte        // Error flags.
);
    wire fast_tick;
    wire slow_tick;
    wire fast_wave;
    wire slow_wave;

    flash_timebase #(
        .HALF_FAST (HALF_FAST),
        .HALF_SLOW (HALF_SLOW)
    ) timebase (
        .mclk      (mclk),
        .reset     (reset),
        .fast_tick (fast_tick),
        .slow_tick (slow_tick),
        .fast_wave (fast_wave),
        .slow_wave (slow_wave)
    );

    // Pulse count for the red indicator; an internal fault wins, then the lowest set flag.
    function [2:0] flash_code;
        input [5:0] flags;
        begin
            if (flags[`DIAG_INTERNAL])
                flash_code = `CODE_CONTINUOUS;
            else if (flags[`DIAG_OUT_A])
                flash_code = 3'h1;
            else if (flags[`DIAG_OUT_B])
                flash_code = 3'h2;
            else if (flags[`DIAG_CROSS])
                flash_code = 3'h3;
            else if (flags[`DIAG_TEMP])
                flash_code = 3'h4;
            else if (flags[`DIAG_ACTUATOR])
                flash_code = 3'h5;
            else
                flash_code = `CODE_NONE;
        end
    endfunction

    reg [5:0]  fault_latch;
    reg        expired;
    reg [10:0] warn_seconds;
    reg        released;
    reg        feedback_prev;
    reg        request_prev_high;
    reg        request_prev_low;
    reg        actuator_prev;
    reg        alt_select;
    reg [3:0]  flash_step;

    wire       inputs_live  = safety_input_a & safety_input_b;
    wire [5:0] cause_masked = fault_cause & 6'h3f;
    wire       any_warning  = |warning_cause | comm_error;
    wire       any_error    = |fault_latch | expired;
    wire       reset_fall   = request_valid &
                              ((request_prev_high & ~host_request_byte[`REQ_RESET_HIGH]) |
                               (request_prev_low  & ~host_request_byte[`REQ_RESET_LOW]));
    wire       guard_opened = actuator_prev & ~actuator_present;
    wire       clear_req    = reset_fall | guard_opened;
    wire       release_cond = variant_edge_feedback ? (feedback_prev & ~feedback_closed)
                                                    : feedback_closed;
    wire       may_release  = actuator_present & inputs_live & ~any_error;
    wire       release_now  = may_release & release_cond;
    wire [7:0] warn_flags   = {warning_cause[`DIAG_LOW_SUPPLY], comm_error,
                               warning_cause[`DIAG_INTERNAL], 1'b0,
                               warning_cause[3:0]};

    reg [5:0] next_fault_latch;
    reg       next_released;
    reg       next_red;
    reg       next_yellow;
    reg       next_diag;
    reg       next_out;
    reg [2:0] code;
    integer   i;

    always @* begin
        // Set wins over clear: a cause still present keeps its flag.
        for (i = 0; i < 6; i = i + 1) begin
            if (cause_masked[i])
                next_fault_latch[i] = 1'b1;
            else if (i <= `DIAG_CROSS && clear_req)
                next_fault_latch[i] = fault_latch[i] & ~release_cond;  // see RULE14
            else if (clear_req)
                next_fault_latch[i] = 1'b0;  // see RULE13
            else
                next_fault_latch[i] = fault_latch[i];
        end

        if (~actuator_present | ~inputs_live | any_error)
            next_released = 1'b0;  // see RULE9
        else if (release_now)
            next_released = 1'b1;  // see RULE6
        else
            next_released = released;

        code = any_error ? flash_code(fault_latch) : flash_code(warn_flags[5:0]);
        if (code == `CODE_CONTINUOUS)
            next_red = 1'b1;  // see RULE20
        else if (code != `CODE_NONE)
            next_red = ({1'b0, flash_step} < {1'b0, code, 1'b0}) & ~flash_step[0];  // see RULE20
        else if (any_error | any_warning)
            next_red = fast_wave;  // see RULE8
        else
            next_red = 1'b0;  // see RULE3

        if (any_error | any_warning)
            next_yellow = 1'b1;  // see RULE8
        else if (~actuator_present)
            next_yellow = 1'b0;  // see RULE3
        else if (~released & limit_area)
            next_yellow = alt_select ? slow_wave : fast_wave;  // see RULE7
        else if (~released)
            next_yellow = fast_wave;  // see RULE6
        else if (limit_area)
            next_yellow = slow_wave;  // see RULE5
        else
            next_yellow = 1'b1;  // see RULE4

        if (any_error | any_warning)
            next_diag = 1'b0;  // see RULE1
        else if (~actuator_present)
            next_diag = 1'b0;  // see RULE3
        else if (limit_area)
            next_diag = slow_wave;  // see RULE5
        else
            next_diag = 1'b1;  // see RULE4

        // Safety outputs follow the release with no error; a lost gateway link holds them unless an error stands.
        if (comm_error & ~any_error)
            next_out = safety_output_a;  // see RULE12
        else
            next_out = released & ~any_error;  // see RULE2
    end

    always @(posedge mclk) begin
        if (reset) begin
            fault_latch          <= 6'h00;
            expired              <= 1'b0;
            warn_seconds         <= 11'h000;
            released             <= 1'b0;
            feedback_prev        <= 1'b0;
            request_prev_high    <= 1'b0;
            request_prev_low     <= 1'b0;
            actuator_prev        <= 1'b0;
            alt_select           <= 1'b0;
            flash_step           <= 4'h0;
            serial_diag_out      <= 1'b0;
            led_green            <= 1'b0;
            led_red              <= 1'b0;
            led_yellow           <= 1'b0;
            diag_output          <= 1'b0;
            safety_output_a      <= 1'b0;
            safety_output_b      <= 1'b0;
            sensor_response_byte <= 8'h00;
            warning_diag_byte    <= 8'h00;
            error_diag_byte      <= 8'h00;
        end else begin
            fault_latch   <= next_fault_latch;
            released      <= next_released;
            feedback_prev <= feedback_closed;
            actuator_prev <= actuator_present;
            if (request_valid) begin
                request_prev_high <= host_request_byte[`REQ_RESET_HIGH];  // see RULE16
                request_prev_low  <= host_request_byte[`REQ_RESET_LOW];
            end

            // Delayed shutdown counts whole slow periods while a warning stands.
            if (any_warning & ~expired) begin
                if (slow_tick & slow_wave) begin
                    if (warn_seconds == SHUTDOWN_SECONDS[10:0] - 11'h001)
                        expired <= 1'b1;  // see RULE2
                    else
                        warn_seconds <= warn_seconds + 11'h001;
                end
            end else if (~any_warning) begin
                warn_seconds <= 11'h000;  // see RULE15
                if (expired & clear_req)
                    expired <= 1'b0;  // see RULE13
            end

            if (slow_tick & slow_wave)
                alt_select <= ~alt_select;  // see RULE7
            if (fast_tick)
                flash_step <= flash_step + 4'h1;

            // Upstream diagnostic data passes on one cycle later.
            serial_diag_out <= serial_diag_in;  // see RULE10

            led_green       <= 1'b1;  // see RULE3
            led_red         <= next_red;
            led_yellow      <= next_yellow;
            diag_output     <= next_diag;
            safety_output_a <= next_out;
            safety_output_b <= next_out;

            sensor_response_byte <= {any_error, any_warning, limit_area & actuator_present,
                                     inputs_live, ~feedback_closed, 1'b0,
                                     actuator_present, next_out};  // see RULE11 RULE19 RULE21
            warning_diag_byte    <= warn_flags;                       // see RULE17
            error_diag_byte      <= {2'h0, fault_latch};             // see RULE18 RULE21
        end
    end
endmodule

/* tb/gateway_model.sv */
/*
 * Controller model: sends an error-reset exchange on command, keeps the
 * serial line moving.
 * Assumes send_reset is raised for one cycle just after a clock edge.
 */
module gateway_model (
    input  wire        mclk,              // Clock.
    input  wire        send_reset,        // Start one exchange.
    output logic [7:0] host_request_byte, // Request byte.
    output logic       request_valid,     // Request byte current.
    output logic       serial_diag_in     // Serial line.
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] phase = 2'h0;
    logic       go;
    initial begin
        host_request_byte = 8'hff;
        request_valid = 1'b0;
        serial_diag_in = 1'b0;
    end
    // Both reset bits go high, then low, so the falling edge is seen; between
    // exchanges the byte keeps changing so a stale value is never trusted.
    always @(posedge mclk) begin
        go = send_reset;
        #1;
        serial_diag_in = ~serial_diag_in ^ phase[0];
        case (phase)
            2'h0: phase = go ? 2'h1 : 2'h0;
            2'h1: phase = 2'h2;
            default: phase = 2'h0;
        endcase
        request_valid = (phase != 2'h0);
        host_request_byte = (phase == 2'h1) ? 8'h81 : ~host_request_byte;
    end
endmodule

/* tb/sensor_status_checker.sv */
/*
 * Concurrent checks on the ports of the diagnostic status block.
 * Assumes it is bound to the top module; one clock, synchronous reset.
 */
module sensor_status_checker (
    input wire       mclk,                  // Clock.
    input wire       reset,                 // Reset.
    input wire       variant_edge_feedback, // Strap.
    input wire       actuator_present,      // Sensing.
    input wire       limit_area,            // Sensing.
    input wire       feedback_closed,       // Sensing.
    input wire       safety_input_a,        // Sensing.
    input wire       safety_input_b,        // Sensing.
    input wire [5:0] fault_cause,           // Faults.
    input wire [7:0] warning_cause,         // Warnings.
    input wire       comm_error,            // Link lost.
    input wire       serial_diag_in,        // Serial in.
    input wire       serial_diag_out,       // Serial out.
    input wire       led_green,             // Indicator.
    input wire       led_red,               // Indicator.
    input wire       led_yellow,            // Indicator.
    input wire       diag_output,           // Diagnostic pin.
    input wire       safety_output_a,       // Output.
    input wire       safety_output_b,       // Output.
    input wire [7:0] sensor_response_byte,  // Status.
    input wire [7:0] warning_diag_byte,     // Warnings.
    input wire [7:0] error_diag_byte        // Errors.
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    sequence s_idle;
        !actuator_present && fault_cause == 6'h00 && warning_cause == 8'h00 && !comm_error
            && sensor_response_byte[7:6] == 2'h0;
    endsequence
    // Every release condition at once; the top status bits stand for latched faults and current warnings.
    sequence s_go;
        actuator_present && !limit_area && feedback_closed && safety_input_a && safety_input_b
            && !variant_edge_feedback && fault_cause == 6'h00 && warning_cause == 8'h00
            && !comm_error && sensor_response_byte[7:6] == 2'h0;
    endsequence
    a_idle_green_only: assert property (
        s_idle ##1 s_idle |=> led_green && !led_red && !led_yellow && !diag_output
            && !safety_output_a) else $error("idle indication wrong");
    a_release_turns_on: assert property (
        s_go [*4] |=> safety_output_a && led_yellow && diag_output)
        else $error("release not shown");
    a_outputs_paired: assert property (
        safety_output_a == safety_output_b) else $error("safety outputs differ");
    a_fault_forces_off: assert property (
        fault_cause != 6'h00 |-> ##2 !diag_output && !safety_output_a && led_yellow
            && sensor_response_byte[7]) else $error("fault not shown");
    a_error_byte_flags: assert property (
        fault_cause != 6'h00 |=> ##1
            (error_diag_byte[5:0] & $past(fault_cause, 2)) == $past(fault_cause, 2))
        else $error("error byte flag missing");
    a_warning_byte_map: assert property (
        1'b1 |=> warning_diag_byte == {$past(warning_cause[7]), $past(comm_error),
            $past(warning_cause[5]), 1'b0, $past(warning_cause[3:0])})
        else $error("warning byte wrong");
    a_warning_diag_low: assert property (
        (warning_diag_byte & 8'hbf) != 8'h00 |-> !diag_output)
        else $error("diagnostic output high in warning");
    a_status_bits: assert property (
        1'b1 |=> sensor_response_byte[4] == ($past(safety_input_a) & $past(safety_input_b))
            && sensor_response_byte[3] == !$past(feedback_closed)
            && sensor_response_byte[1] == $past(actuator_present)
            && sensor_response_byte[0] == safety_output_a && !sensor_response_byte[2]
            && error_diag_byte[7:6] == 2'h0) else $error("response byte wrong");
    a_comm_freeze: assert property (
        comm_error && !sensor_response_byte[7] && fault_cause == 6'h00
            ##1 !sensor_response_byte[7] |-> $stable(safety_output_a))
        else $error("outputs moved on link loss");
    a_serial_relay: assert property (
        !$past(reset) |=> serial_diag_out == $past(serial_diag_in))
        else $error("serial line not relayed");
endmodule

bind safety_sensor_diagnostic_status sensor_status_checker sensor_status_checker_inst (
    .mclk(mclk), .reset(reset), .variant_edge_feedback(variant_edge_feedback),
    .actuator_present(actuator_present), .limit_area(limit_area),
    .feedback_closed(feedback_closed), .safety_input_a(safety_input_a),
    .safety_input_b(safety_input_b), .fault_cause(fault_cause),
    .warning_cause(warning_cause), .comm_error(comm_error), .serial_diag_in(serial_diag_in),
    .serial_diag_out(serial_diag_out), .led_green(led_green), .led_red(led_red),
    .led_yellow(led_yellow), .diag_output(diag_output), .safety_output_a(safety_output_a),
    .safety_output_b(safety_output_b), .sensor_response_byte(sensor_response_byte),
    .warning_diag_byte(warning_diag_byte), .error_diag_byte(error_diag_byte));

/* tb/tb_safety_sensor_diagnostic_status.sv */
/*
 * Self-checking bench: idle, release, flashing, faults and codes, warnings,
 * delayed shutdown, link loss and random sensing.
 * Assumes short flash and shutdown counts so the run stays brief.
 */
module tb_safety_sensor_diagnostic_status;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HF = 4;
    localparam int HS = 20;
    localparam int SECS = 3;
    logic       mclk, reset, variant_edge_feedback, actuator_present, limit_area;
    logic       feedback_closed, safety_input_a, safety_input_b, comm_error, send_reset;
    logic       request_valid, serial_diag_in;
    logic [5:0] fault_cause;
    logic [7:0] warning_cause, host_request_byte;
    wire        serial_diag_out, led_green, led_red, led_yellow, diag_output;
    wire        safety_output_a, safety_output_b;
    wire  [7:0] sensor_response_byte, warning_diag_byte, error_diag_byte;
    wire  [7:0] all_out = {2'h0, led_red, diag_output, safety_output_a, safety_output_b,
                           led_green, led_yellow};
    int         miscompares = 0;
    int         total_checks = 0;
    int         seed = 59550;
    int         i;
    int         n;
    safety_sensor_diagnostic_status #(.HALF_FAST(HF), .HALF_SLOW(HS), .SHUTDOWN_SECONDS(SECS))
        safety_sensor_diagnostic_status_inst (.mclk(mclk), .reset(reset),
        .variant_edge_feedback(variant_edge_feedback), .actuator_present(actuator_present),
        .limit_area(limit_area), .feedback_closed(feedback_closed),
        .safety_input_a(safety_input_a), .safety_input_b(safety_input_b),
        .fault_cause(fault_cause), .warning_cause(warning_cause), .comm_error(comm_error),
        .host_request_byte(host_request_byte), .request_valid(request_valid),
        .serial_diag_in(serial_diag_in), .serial_diag_out(serial_diag_out),
        .led_green(led_green), .led_red(led_red), .led_yellow(led_yellow),
        .diag_output(diag_output), .safety_output_a(safety_output_a),
        .safety_output_b(safety_output_b), .sensor_response_byte(sensor_response_byte),
        .warning_diag_byte(warning_diag_byte), .error_diag_byte(error_diag_byte));
    gateway_model gateway_model_inst (.mclk(mclk), .send_reset(send_reset),
        .host_request_byte(host_request_byte), .request_valid(request_valid),
        .serial_diag_in(serial_diag_in));
    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    // Order: variant, actuator, limit, feedback, input a, input b.
    task automatic sense(input logic [5:0] v);
        {variant_edge_feedback, actuator_present, limit_area, feedback_closed,
            safety_input_a, safety_input_b} = v;
    endtask
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // A window of whole flash periods gives an exact count whatever the phase.
    task automatic flips(input string what, input int b, input int k, input logic [7:0] exp);
        logic prev;
        int   cnt;
        prev = all_out[b];
        cnt = 0;
        repeat (k) begin
            cyc(1);
            if (all_out[b] !== prev) cnt++;
            prev = all_out[b];
        end
        check(what, exp, cnt[7:0]);
    endtask
    task automatic clear_req;
        send_reset = 1'b1;
        cyc(1);
        send_reset = 1'b0;
        cyc(6);
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    function automatic logic [7:0] exp_status(input logic [5:0] v);
        return {2'h0, v[3] & v[4], v[1] & v[0], ~v[2], 1'b0, v[4], 1'b0};
    endfunction
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    initial begin
        reset = 1'b1;
        sense(6'h00);
        fault_cause = 6'h00;
        warning_cause = 8'h00;
        comm_error = 1'b0;
        send_reset = 1'b0;
        cyc(6);
        reset = 1'b0;
        cyc(3);
        check("idle pins", 8'h02, all_out);
        sense(6'h17);
        cyc(3);
        check("release pins", 8'h1f, all_out);
        check("release status", 8'h13, sensor_response_byte);
        sense(6'h1f);
        cyc(2);
        check("limit pins", 8'h0e, all_out & 8'h0e);
        flips("limit yellow", 0, 2 * HS, 8'h02);
        // The release is latched, so the actuator leaves first to reach the wait state.
        sense(6'h03);
        cyc(2);
        sense(6'h13);
        cyc(3);
        check("open pins", 8'h12, all_out & 8'h1e);
        flips("open yellow", 0, 2 * HS, 8'(2 * HS / HF));
        sense(6'h1b);
        cyc(3);
        check("limit open pins", 8'h02, all_out & 8'h0e);
        sense(6'h37);
        cyc(4);
        check("edge wait", 8'h00, all_out & 8'h0c);
        sense(6'h33);
        cyc(4);
        check("edge release", 8'h1f, all_out);
        $display("test indication done");
        for (i = 0; i < 40; i++) begin
            n = $random(seed);
            sense({1'b0, n[4:0]});
            cyc(1);
            check("status", exp_status({1'b0, n[4:0]}), sensor_response_byte & 8'hfe);
        end
        $display("test random done");
        sense(6'h17);
        cyc(3);
        for (i = 0; i < 6; i++) begin
            fault_cause = 6'h01 << i;
            cyc(3);
            fault_cause = 6'h00;
            check("error byte", 8'h01 << i, error_diag_byte);
            check("error pins", 8'h03, all_out & 8'h1f);
            check("error status", 8'h80, sensor_response_byte & 8'hc1);
            if (i < 5) flips("red code", 5, 16 * HF, 8'(2 * i + 2));
            else check("red steady", 8'h20, all_out & 8'h20);
            clear_req();
            check("cleared", 8'h00, error_diag_byte);
            check("re-release", 8'h1f, all_out);
        end
        fault_cause = 6'h08;
        cyc(3);
        fault_cause = 6'h00;
        sense(6'h07);
        cyc(3);
        check("guard clear", 8'h00, error_diag_byte);
        sense(6'h17);
        cyc(3);
        $display("test faults done");
        for (i = 0; i < 8; i++) begin
            warning_cause = 8'h01 << i;
            cyc(2);
            check("warn byte", (i == 4 || i == 6) ? 8'h00 : 8'h01 << i, warning_diag_byte);
            check("warn pins", 8'h0f, all_out & 8'h1f);
        end
        warning_cause = 8'h00;
        cyc(2);
        check("warn gone", 8'h1f, all_out);
        warning_cause = 8'h80;
        cyc((SECS - 1) * 2 * HS);
        check("before expiry", 8'h0c, all_out & 8'h0c);
        n = 0;
        while (safety_output_a !== 1'b0 && n < 4 * 2 * HS) begin
            cyc(1);
            n++;
        end
        check("expired", 8'h80, sensor_response_byte & 8'h81);
        check("expiry wait", 8'h00, {7'h00, n == 4 * 2 * HS});
        if (n == 4 * 2 * HS) conclude();
        warning_cause = 8'h00;
        clear_req();
        check("after expiry", 8'h1f, all_out);
        comm_error = 1'b1;
        sense(6'h07);
        cyc(3);
        check("link flag", 8'h40, warning_diag_byte);
        check("link hold", 8'h0c, all_out & 8'h0c);
        comm_error = 1'b0;
        cyc(3);
        check("link over", 8'h02, all_out);
        $display("test warnings done");
        conclude();
    end
endmodule
